/* sim/pci_host_access_decoder_test.sv */
// Self-checking bench: host, unit and local bus traffic through the decoder.
`default_nettype none
module pci_host_access_decoder_test
   import phd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, sys_rst = 1'b1; // Clock and synchronous reset.
   logic host_req = 1'b0, host_io = 1'b0, host_write = 1'b0; // Host request group.
   logic [31:0] host_addr = 32'h0, host_wdata = 32'h0;
   logic ras_req = 1'b0, seg_req = 1'b0, u_write = 1'b0; // Both units share the fields.
   logic [BASE_W-1:0] u_base = 24'h0;
   logic [OFFS_W-1:0] u_offs = 16'h0;
   logic [DATA_W-1:0] u_wdata = 32'h0, reg_rdata = 32'h0;
   logic [7:0] ready_delay = 8'h00; // Peripheral answer delay in cycles.
   logic host_wait, host_done, host_aborted, ras_done, seg_done, reg_strobe, reg_write;
   logic local_data_bus_oe, local_memory_select, peripheral_select, local_write;
   logic peripheral_ready, peripheral_abort_event;
   logic [DATA_W-1:0] host_rdata, unit_rdata, reg_wdata, local_data_bus_out, local_data_bus_in;
   logic [REG_AW-1:0] reg_addr;
   logic [LA_W-1:0] local_address_out;
   logic saw_lcs, saw_pcs, saw_reg, saw_wait, saw_abort, cap_wr, cap_ab; // Monitor flags.
   logic [31:0] cap_la, cap_ld, cap_raddr, cap_rwd, cap_rd, cap_urd; // Captured words.
   logic [11:0] order; // Finish order: 1 reassembly, 2 host, 3 segmentation.
   int err_total = 0, n_checks = 0, lat, lat_mem;
   pci_host_access_decoder u_dut (
      .clock, .sys_rst, .host_req, .host_io, .host_write, .host_addr, .host_wdata, .host_wait,
      .host_done, .host_aborted, .host_rdata, .ras_req, .ras_write(u_write), .ras_base(u_base),
      .ras_offset(u_offs), .ras_wdata(u_wdata), .ras_done, .seg_req, .seg_write(u_write),
      .seg_base(u_base), .seg_offset(u_offs), .seg_wdata(u_wdata), .seg_done, .unit_rdata,
      .reg_strobe, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .local_address_out,
      .local_data_bus_out, .local_data_bus_oe, .local_data_bus_in, .local_memory_select,
      .peripheral_select, .local_write, .peripheral_ready, .peripheral_abort_event);
   phd_far_model u_far (
      .clock, .local_address_out, .local_data_bus_out, .local_data_bus_oe, .local_memory_select,
      .peripheral_select, .local_write, .ready_delay, .local_data_bus_in, .peripheral_ready);
   // Free-running 25 MHz clock.
   initial begin
      forever #20 clock = ~clock;
   end
   // Watches the outputs; register reads are answered the cycle after the strobe.
   always @(posedge clock) begin
      if (local_memory_select) saw_lcs <= 1'b1;
      if (peripheral_select) saw_pcs <= 1'b1;
      if (host_wait) saw_wait <= 1'b1;
      if (peripheral_abort_event) saw_abort <= 1'b1;
      if (local_memory_select | peripheral_select) cap_la <= {12'h0, local_address_out};
      if (local_data_bus_oe) cap_ld <= local_data_bus_out;
      if (reg_strobe) begin
         {saw_reg, cap_wr, cap_raddr, cap_rwd} <= {1'b1, reg_write, 16'h0, reg_addr, reg_wdata};
         reg_rdata <= {16'h5a5a, reg_addr};
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic clear;
      {saw_lcs, saw_pcs, saw_reg, saw_wait, saw_abort, cap_wr, cap_la} = 38'h0;
   endtask
   // Serves every raised request, dropping each in its done cycle; a hang ends the run.
   task automatic drain;
      order = 12'h000;
      for (lat = 0; lat < 300 && (ras_req || host_req || seg_req); lat++) begin
         @(negedge clock);
         if (ras_done === 1'b1) begin
            {order, cap_urd, ras_req} = {order[7:0], 4'h1, unit_rdata, 1'b0};
         end
         if (host_done === 1'b1) begin
            {order, cap_ab, cap_rd, host_req} = {order[7:0], 4'h2, host_aborted, host_rdata, 1'b0};
         end
         if (seg_done === 1'b1) begin
            {order, cap_urd, seg_req} = {order[7:0], 4'h3, unit_rdata, 1'b0};
         end
      end
      if (lat >= 300) begin
         err_total++;
         report_and_stop();
      end
      @(negedge clock);
   endtask
   task automatic host(input logic io, input logic wr, input logic [31:0] a, input logic [31:0] d);
      clear();
      {host_io, host_write, host_addr, host_wdata, host_req} = {io, wr, a, d, 1'b1};
      drain();
   endtask
   task automatic unit(input logic r, input logic wr, input logic [23:0] b, input logic [15:0] o,
                       input logic [31:0] d);
      clear();
      {u_write, u_base, u_offs, u_wdata, ras_req, seg_req} = {wr, b, o, d, r, !r};
      drain();
   endtask
   // Local RAM write and read with ready held low: memory must not wait on it.
   task automatic t_local;
      ready_delay = 8'hff;
      host(1'b0, 1'b1, 32'h0031_2344, 32'hdead_beef);
      check(cap_ld, 32'hdead_beef);
      check({saw_lcs, saw_pcs}, 2'b10);
      host(1'b0, 1'b0, 32'h0031_2344, 32'h0);
      lat_mem = lat;
      check(cap_rd, 32'hdead_beef);
      check(cap_la, 32'h000c_48d1);
   endtask
   // On-chip write, read back through a mirror with bits 12 to 21 set.
   task automatic t_onchip;
      host(1'b0, 1'b1, 32'h0040_0010, 32'ha5a5_0001);
      check({saw_lcs, saw_pcs}, 2'b00);
      host(1'b0, 1'b0, 32'h007f_f010, 32'h0);
      check(cap_rd, 32'ha5a5_0001);
   endtask
   // Peripheral through both 1x codes, fast and slow ready.
   task automatic t_periph;
      ready_delay = 8'h00;
      host(1'b0, 1'b1, 32'h00c0_0104, 32'h1234_5678);
      check({saw_lcs, saw_pcs}, 2'b01);
      check(cap_la, 32'h0000_0041);
      ready_delay = 8'h06;
      host(1'b0, 1'b0, 32'h0080_0104, 32'h0);
      check(cap_rd, 32'h1234_5678);
      check(lat >= lat_mem + 6, 1'b1);
   endtask
   // I/O accesses reach registers even with peripheral bits set in the address.
   task automatic t_regs;
      host(1'b1, 1'b1, 32'h00c0_0124, 32'hcafe_f00d);
      check({saw_reg, saw_lcs, saw_pcs, cap_wr}, 4'b1001);
      check(cap_raddr, 32'h0000_0124);
      check(cap_rwd, 32'hcafe_f00d);
      host(1'b1, 1'b0, 32'h0000_0248, 32'h0);
      check(cap_rd, 32'h5a5a_0248);
   endtask
   // Unit addressing: external, on-chip by base bits, and the 10 boundary.
   task automatic t_unit;
      unit(1'b1, 1'b1, 24'h00_0123, 16'h0005, 32'h7777_0001);
      check(cap_la, 32'h0000_48c5);
      check({saw_lcs, saw_pcs}, 2'b10);
      unit(1'b0, 1'b0, 24'h00_0123, 16'h0005, 32'h0);
      check(cap_urd, 32'h7777_0001);
      unit(1'b1, 1'b1, 24'h00_4000, 16'h0007, 32'h0bad_cafe);
      check({saw_lcs, saw_pcs}, 2'b00);
      host(1'b0, 1'b0, 32'h0040_001c, 32'h0);
      check(cap_rd, 32'h0bad_cafe);
      unit(1'b1, 1'b1, 24'h00_8000, 16'h0007, 32'h0);
      check({saw_lcs, cap_la[19:0]}, 21'h1_00007);
   endtask
   // All three requesters raised in one cycle.
   task automatic t_priority;
      clear();
      {host_io, host_write, host_addr, host_req} = {1'b0, 1'b0, 32'h0031_2344, 1'b1};
      {u_write, u_base, u_offs, ras_req, seg_req} = {1'b0, 24'h00_0123, 16'h0005, 2'b11};
      drain();
      check(order, 12'h123);
      check(saw_wait, 1'b1);
      check(cap_rd, 32'hdead_beef);
   endtask
   // Reassembly request during a stalled peripheral read, then a clean retry.
   task automatic t_abort;
      ready_delay = 8'hff;
      clear();
      {host_io, host_write, host_addr, host_req} = {1'b0, 1'b0, 32'h0080_0200, 1'b1};
      repeat (8) @(negedge clock);
      {u_write, u_base, u_offs, u_wdata, ras_req} = {1'b1, 24'h00_0123, 16'h6, 32'h0, 1'b1};
      drain();
      check(order, 12'h021);
      check({cap_ab, saw_abort}, 2'b11);
      ready_delay = 8'h00;
      host(1'b0, 1'b0, 32'h0080_0104, 32'h0);
      check({cap_ab, cap_rd}, {1'b0, 32'h1234_5678});
   endtask
   // Reset for 20 cycles, then every scenario in turn.
   initial begin
      repeat (20) @(negedge clock);
      check({host_done, ras_done, seg_done, reg_strobe, peripheral_abort_event}, 5'h00);
      check({local_memory_select, peripheral_select, local_data_bus_oe}, 3'h0);
      sys_rst = 1'b0;
      @(negedge clock);
      t_local();
      t_onchip();
      t_periph();
      t_regs();
      t_unit();
      t_priority();
      t_abort();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* sim/phd_far_model.sv */
// Behavioural local RAM and peripheral answering on the local bus.
`default_nettype none
module phd_far_model
   import phd_pkg::*;
(
   input wire logic clock,
   input wire logic [LA_W-1:0] local_address_out,
   input wire logic [DATA_W-1:0] local_data_bus_out,
   input wire logic local_data_bus_oe,
   input wire logic local_memory_select,
   input wire logic peripheral_select,
   input wire logic local_write,
   input wire logic [7:0] ready_delay,
   output logic [DATA_W-1:0] local_data_bus_in,
   output logic peripheral_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] ram_mem [256]; // Only low address bits are kept, to stay small.
   logic [DATA_W-1:0] dev_mem [256]; // Peripheral store, double-word indexed.
   logic [DATA_W-1:0] last_word = 32'h0; // Last word driven by the model.
   logic [7:0] wait_cnt = 8'h00; // Cycles spent selected by a peripheral access.
   wire logic sel_any = local_memory_select | peripheral_select;
   wire logic [7:0] idx = local_address_out[7:0];
   wire logic [DATA_W-1:0] rd_word = peripheral_select ? dev_mem[idx] : ram_mem[idx];
   // A released bus shows the inverse of its last word, so stale data never matches.
   assign local_data_bus_in = (sel_any && !local_write) ? rd_word : ~last_word;
   // Delay zero stands for a fast peripheral whose ready pin is tied high.
   assign peripheral_ready = (ready_delay == 8'h00) ||
      (peripheral_select && wait_cnt >= ready_delay);
   // Stores happen only while write strobe and data enable stand together.
   always_ff @(posedge clock) begin
      if (sel_any && !local_write) begin
         last_word <= rd_word;
      end
      if (local_memory_select && local_write && local_data_bus_oe) begin
         ram_mem[idx] <= local_data_bus_out;
      end
      if (peripheral_select && local_write && local_data_bus_oe) begin
         dev_mem[idx] <= local_data_bus_out;
      end
      // The count saturates at 255, so a delay of 255 still raises ready after 255 selected cycles.
      if (!peripheral_select) begin
         wait_cnt <= 8'h00;
      end else if (wait_cnt != 8'hff) begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* src/pci_host_access_decoder.sv */
// Host access decoder and local bus sequencer with fixed-priority arbitration.
// Function
// RULE_01: Host memory AD23:22 pick local, on-chip, peripheral.
// RULE_02: Registers reached by host through I/O accesses.
// RULE_03: On-chip RAM 4 Kbytes, mirrored across window.
// RULE_04: Internal address is base times 64 plus offset.
// RULE_05: Internal address bits 21:20 equal 01 mean on-chip.
// RULE_06: Software keeps on-chip structures inside 01 region.
// RULE_07: Host AD21:2 onto local address, data unchanged.
// RULE_08: Peripheral uses same mapping, double-word addresses.
// RULE_09: Peripheral access raises peripheral select only.
// RULE_10: Peripheral waits for ready, memory never waits.
// RULE_11: Zero-wait peripheral may tie ready high.
// RULE_12: Reassembly request aborts peripheral access, flags event.
// RULE_13: Priority: reassembly, then host, then segmentation.
// RULE_14: Host held off while another owner holds bus.
`default_nettype none
module pci_host_access_decoder
   import phd_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic host_req,
   input wire logic host_io,
   input wire logic host_write,
   input wire logic [31:0] host_addr,
   input wire logic [DATA_W-1:0] host_wdata,
   output logic host_wait,
   output logic host_done,
   output logic host_aborted,
   output logic [DATA_W-1:0] host_rdata,
   input wire logic ras_req,
   input wire logic ras_write,
   input wire logic [BASE_W-1:0] ras_base,
   input wire logic [OFFS_W-1:0] ras_offset,
   input wire logic [DATA_W-1:0] ras_wdata,
   output logic ras_done,
   input wire logic seg_req,
   input wire logic seg_write,
   input wire logic [BASE_W-1:0] seg_base,
   input wire logic [OFFS_W-1:0] seg_offset,
   input wire logic [DATA_W-1:0] seg_wdata,
   output logic seg_done,
   output logic [DATA_W-1:0] unit_rdata,
   output logic reg_strobe,
   output logic reg_write,
   output logic [REG_AW-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   output logic [LA_W-1:0] local_address_out,
   output logic [DATA_W-1:0] local_data_bus_out,
   output logic local_data_bus_oe,
   input wire logic [DATA_W-1:0] local_data_bus_in,
   output logic local_memory_select,
   output logic peripheral_select,
   output logic local_write,
   input wire logic peripheral_ready,
   output logic peripheral_abort_event
);
   phd_state_t state; // Sequencer state.
   phd_state_t next_state; // Sequencer state for the next cycle.
   phd_owner_t owner; // Requester of the access in flight.
   phd_target_t target; // Destination of the access in flight.
   logic cur_write; // Access in flight is a write.
   logic [DATA_W-1:0] cur_wdata; // Write word of the access in flight.
   logic [RAM_AW-1:0] cur_ridx; // On-chip RAM index of the access in flight.
   logic [IADDR_W-1:0] cur_iaddr; // Internal word address of a unit access.
   logic [31:0] cur_haddr; // Host address of a host access.
   logic rdy_s1; // Ready synchroniser, first stage.
   logic rdy_s2; // Ready synchroniser, second stage.
   logic rdy_s3; // Ready synchroniser, third stage.
   logic rdy_level; // Filtered ready level.

   phd_ram_if ram_bus();

   // Grant decode; a done pulse blocks a new grant so a requester can drop its request.
   wire any_done = host_done | ras_done | seg_done;
   wire idle_free = (state == PHD_IDLE) && !any_done;
   wire gnt_ras = idle_free && ras_req; // [RULE_13]
   wire gnt_host = idle_free && host_req && !ras_req; // [RULE_13]
   wire gnt_seg = idle_free && seg_req && !ras_req && !host_req; // [RULE_13]
   wire gnt_any = gnt_ras | gnt_host | gnt_seg;

   // Unit address formation; both units share the same helper.
   wire [IADDR_W-1:0] ras_iaddr = phd_form_iaddr(ras_base, ras_offset); // [RULE_04]
   wire [IADDR_W-1:0] seg_iaddr = phd_form_iaddr(seg_base, seg_offset); // [RULE_04]
   wire [IADDR_W-1:0] unit_iaddr = gnt_ras ? ras_iaddr : seg_iaddr;
   wire unit_onchip = unit_iaddr[IADDR_SEL_HI:IADDR_SEL_LO] == IADDR_ONCHIP; // [RULE_05]

   // Host target decode: I/O goes to registers, memory splits on AD23:22.
   wire [1:0] host_sel = host_addr[HOST_SEL_HI:HOST_SEL_LO];
   wire host_periph = host_sel[1]; // [RULE_01]
   wire host_onchip = host_sel == SEL_ONCHIP; // [RULE_01]
   phd_target_t host_tgt;
   phd_target_t unit_tgt;
   phd_target_t grant_tgt;
   assign host_tgt = host_io ? PHD_TGT_REGS : // [RULE_02]
                     host_periph ? PHD_TGT_PERIPH :
                     host_onchip ? PHD_TGT_ONCHIP : PHD_TGT_LOCAL;
   assign unit_tgt = unit_onchip ? PHD_TGT_ONCHIP : PHD_TGT_LOCAL; // [RULE_05]
   assign grant_tgt = gnt_host ? host_tgt : unit_tgt;

   // Selected fields of the winning request.
   wire grant_write = gnt_host ? host_write : (gnt_ras ? ras_write : seg_write);
   wire [DATA_W-1:0] grant_wdata = gnt_host ? host_wdata : (gnt_ras ? ras_wdata : seg_wdata);
   // Host word index ignores AD12-21, so the RAM repeats through the window.
   wire [RAM_AW-1:0] grant_ridx = gnt_host ? host_addr[HOST_RAM_HI:HOST_RAM_LO] // [RULE_03]
                                           : unit_iaddr[RAM_AW-1:0];
   // Host AD21:2 is a double-word address on the local pins.
   wire [LA_W-1:0] grant_la = gnt_host ? host_addr[HOST_LA_HI:HOST_LA_LO] // [RULE_07] [RULE_08]
                                       : unit_iaddr[LA_W-1:0];
   wire grant_ext = (grant_tgt == PHD_TGT_LOCAL) || (grant_tgt == PHD_TGT_PERIPH);
   wire leaving = state == PHD_FINISH;
   wire abort_now = (state == PHD_PWAIT) && ras_req; // [RULE_12]
   phd_owner_t grant_owner;
   assign grant_owner = gnt_ras ? PHD_OWN_RAS : (gnt_host ? PHD_OWN_HOST : PHD_OWN_SEG);
   wire [DATA_W-1:0] finish_rdata = (target == PHD_TGT_ONCHIP) ? ram_bus.rdata :
                                    (target == PHD_TGT_REGS) ? reg_rdata : local_data_bus_in;
   // Host waits whenever it asks but another owner holds the bus.
   wire next_host_wait = host_req && !gnt_host && // [RULE_14]
                         !((state != PHD_IDLE) && (owner == PHD_OWN_HOST));

   // RAM port is driven from the latched access, write only in the issue cycle.
   assign ram_bus.addr = cur_ridx;
   assign ram_bus.we = (state == PHD_ISSUE) && (target == PHD_TGT_ONCHIP) && cur_write;
   assign ram_bus.wdata = cur_wdata;

   phd_onchip_ram u_ram (
      .clock(clock),
      .ram(ram_bus.mem)
   );

   // Sequencer: memory and register accesses never wait, peripherals wait on ready.
   always_comb begin
      next_state = state;
      case (state)
         PHD_IDLE: begin
            if (gnt_any) begin
               next_state = PHD_ISSUE;
            end
         end
         PHD_ISSUE: begin
            next_state = (target == PHD_TGT_PERIPH) ? PHD_PWAIT : PHD_FINISH; // [RULE_10]
         end
         PHD_PWAIT: begin
            if (abort_now || rdy_level) begin // [RULE_10] [RULE_12]
               next_state = PHD_FINISH;
            end
         end
         default: begin
            next_state = PHD_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock) begin
      state <= sys_rst ? PHD_IDLE : next_state;
   end

   // Each grant flushes the ready pipe, so a ready left high by the last access,
   // still travelling through the three stages, cannot end the new access early.
   wire rdy_flush = sys_rst || gnt_any; // [RULE_10]

   // Ready pin passes three flops; the level moves only when stages two and three agree.
   // A peripheral that holds ready high still sees a few waits while the pipe refills.
   always_ff @(posedge clock) begin
      rdy_s1 <= rdy_flush ? 1'b0 : peripheral_ready;
      rdy_s2 <= rdy_flush ? 1'b0 : rdy_s1;
      rdy_s3 <= rdy_flush ? 1'b0 : rdy_s2;
      rdy_level <= rdy_flush ? 1'b0 : ((rdy_s2 == rdy_s3) ? rdy_s3 : rdy_level); // [RULE_11]
   end

   // Latch the winning request; held until the access ends.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         owner <= PHD_OWN_NONE;
         target <= PHD_TGT_LOCAL;
         cur_write <= 1'b0;
         cur_wdata <= DATA_RST;
         cur_ridx <= '0;
         cur_iaddr <= '0;
         cur_haddr <= 32'h00000000;
      end else if (gnt_any) begin
         owner <= grant_owner;
         target <= grant_tgt;
         cur_write <= grant_write;
         cur_wdata <= grant_wdata;
         cur_ridx <= grant_ridx;
         cur_iaddr <= unit_iaddr;
         cur_haddr <= host_addr;
      end
   end

   // Local bus pins: selects stand from grant until finish or abort.
   always_ff @(posedge clock) begin
      if (sys_rst || leaving || abort_now) begin
         local_memory_select <= 1'b0;
         peripheral_select <= 1'b0;
         local_data_bus_oe <= 1'b0;
         local_write <= 1'b0;
      end else if (gnt_any) begin
         local_memory_select <= grant_tgt == PHD_TGT_LOCAL; // [RULE_09]
         peripheral_select <= grant_tgt == PHD_TGT_PERIPH; // [RULE_09]
         local_data_bus_oe <= grant_write && grant_ext; // [RULE_07]
         local_write <= grant_write && grant_ext;
      end
   end

   // Address and data pins follow the grant; the data word passes unchanged.
   always_ff @(posedge clock) begin
      local_address_out <= sys_rst ? LA_RST : (gnt_any ? grant_la : local_address_out);
      local_data_bus_out <= sys_rst ? DATA_RST : (gnt_any ? grant_wdata : local_data_bus_out);
   end

   // Register port: one strobe cycle per host I/O access.
   always_ff @(posedge clock) begin
      reg_strobe <= !sys_rst && gnt_host && host_io; // [RULE_02]
      reg_write <= !sys_rst && gnt_host && host_io && host_write;
      reg_addr <= sys_rst ? '0 : (gnt_host ? host_addr[REG_AW-1:0] : reg_addr);
      reg_wdata <= sys_rst ? DATA_RST : (gnt_host ? host_wdata : reg_wdata);
   end

   // Completion pulses and read data, all in the cycle after finish.
   always_ff @(posedge clock) begin
      host_done <= !sys_rst && leaving && (owner == PHD_OWN_HOST);
      ras_done <= !sys_rst && leaving && (owner == PHD_OWN_RAS);
      seg_done <= !sys_rst && leaving && (owner == PHD_OWN_SEG);
      host_wait <= !sys_rst && next_host_wait;
      peripheral_abort_event <= !sys_rst && abort_now; // [RULE_12]
      host_aborted <= sys_rst ? 1'b0 : (abort_now ? 1'b1 : (gnt_any ? 1'b0 : host_aborted));
   end

   // Read data holding registers, one per side.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         host_rdata <= DATA_RST;
         unit_rdata <= DATA_RST;
      end else if (leaving && !host_aborted) begin
         if (owner == PHD_OWN_HOST) begin
            host_rdata <= finish_rdata;
         end else begin
            unit_rdata <= finish_rdata;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_select_exclusive: assert property (!(local_memory_select && peripheral_select)) // [RULE_09]
      else $error("both local selects active");
   a_periph_select: assert property ((state == PHD_ISSUE && target == PHD_TGT_PERIPH) // [RULE_01]
      |-> peripheral_select && !local_memory_select) else $error("peripheral not selected");
   a_onchip_quiet: assert property ((state == PHD_ISSUE && target == PHD_TGT_ONCHIP) // [RULE_01]
      |-> !local_memory_select && !peripheral_select) else $error("on-chip access on local bus");
   a_host_la_map: assert property ((state == PHD_ISSUE && owner == PHD_OWN_HOST // [RULE_07]
      && target == PHD_TGT_LOCAL) |-> local_address_out == cur_haddr[21:2])
      else $error("host local address wrong");
   a_host_ram_idx: assert property ((state == PHD_ISSUE && owner == PHD_OWN_HOST // [RULE_03]
      && target == PHD_TGT_ONCHIP) |-> ram_bus.addr == cur_haddr[11:2])
      else $error("host RAM index wrong");
   a_unit_onchip: assert property ((state == PHD_ISSUE && owner != PHD_OWN_HOST) // [RULE_05]
      |-> ((cur_iaddr[21:20] == 2'h1) == (target == PHD_TGT_ONCHIP)))
      else $error("unit on-chip decode wrong");
   a_mem_no_wait: assert property ((state == PHD_ISSUE && target != PHD_TGT_PERIPH) // [RULE_10]
      |=> state == PHD_FINISH ##1 ras_done || host_done || seg_done)
      else $error("memory access waited");
   a_periph_held: assert property ((state == PHD_PWAIT && !rdy_level && !ras_req) // [RULE_10]
      |=> state == PHD_PWAIT && peripheral_select) else $error("peripheral wait left early");
   a_abort_flag: assert property ((state == PHD_PWAIT && ras_req) // [RULE_12]
      |=> peripheral_abort_event && !peripheral_select ##1 host_aborted && host_done)
      else $error("abort not flagged");
   a_ras_first: assert property ((idle_free && ras_req) |=> owner == PHD_OWN_RAS) // [RULE_13]
      else $error("reassembly not first");
   a_seg_last: assert property ((idle_free && host_req && !ras_req) // [RULE_13]
      |=> owner == PHD_OWN_HOST) else $error("host lost to segmentation");
   a_host_holdoff: assert property ((host_req && state != PHD_IDLE // [RULE_14]
      && owner != PHD_OWN_HOST) |=> host_wait) else $error("host not held off");
   a_io_strobe: assert property ((gnt_host && host_io) |=> reg_strobe && !local_memory_select) // [RULE_02]
      else $error("register access missing");

   c_periph_wait: cover property (state == PHD_PWAIT ##1 state == PHD_PWAIT ##1 rdy_level);
   c_abort: cover property (peripheral_abort_event);
   c_onchip_host: cover property (gnt_host && host_onchip && !host_io);
   c_unit_onchip: cover property (gnt_seg && unit_onchip);
endmodule
`default_nettype wire

/* src/phd_onchip_ram.sv */
// On-chip RAM of 4 Kbytes built from flip-flops with a registered read.
`default_nettype none
module phd_onchip_ram
   import phd_pkg::*;
(
   input wire logic clock,
   phd_ram_if.mem ram
);
   // Storage array, indexed by word.
   logic [DATA_W-1:0] mem_q [RAM_WORDS];

   // Writes land on the clock edge; no reset so the array maps to plain storage.
   always_ff @(posedge clock) begin
      if (ram.we) begin
         mem_q[ram.addr] <= ram.wdata;
      end
   end

   // Read is registered, so data follows the address by one cycle.
   always_ff @(posedge clock) begin
      ram.rdata <= mem_q[ram.addr];
   end
endmodule
`default_nettype wire

/* src/phd_pkg.sv */
// Constants, types and decode helpers shared by the host access decoder.
`default_nettype none
package phd_pkg;
   // Host memory window select bits and their codes.
   localparam int HOST_SEL_HI = 23;
   localparam int HOST_SEL_LO = 22;
   localparam logic [1:0] SEL_LOCAL_RAM = 2'h0;
   localparam logic [1:0] SEL_ONCHIP = 2'h1;
   // Host address bits that land on the local address pins.
   localparam int HOST_LA_HI = 21;
   localparam int HOST_LA_LO = 2;
   // On-chip RAM: 4 Kbytes, that is 1024 words of 32 bits.
   localparam int RAM_WORDS = 1024;
   localparam int RAM_AW = 10;
   localparam int HOST_RAM_HI = 11;
   localparam int HOST_RAM_LO = 2;
   // Widths of the local bus and of the internal word address.
   localparam int LA_W = 20;
   localparam int DATA_W = 32;
   localparam int BASE_W = 24;
   localparam int OFFS_W = 16;
   localparam int BASE_SHIFT = 6;
   localparam int IADDR_W = 30;
   localparam int REG_AW = 16;
   // Internal word address bits that pick the on-chip RAM, and their code.
   localparam int IADDR_SEL_HI = 21;
   localparam int IADDR_SEL_LO = 20;
   localparam logic [1:0] IADDR_ONCHIP = 2'h1;
   // Reset value of the local bus and data outputs.
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [LA_W-1:0] LA_RST = 20'h00000;

   // Access sequencer states, Gray coded along idle, issue, wait, finish.
   typedef enum logic [1:0] {
      PHD_IDLE = 2'h0,
      PHD_ISSUE = 2'h1,
      PHD_PWAIT = 2'h3,
      PHD_FINISH = 2'h2
   } phd_state_t;

   // Which requester owns the current access.
   typedef enum logic [1:0] {
      PHD_OWN_NONE = 2'h0,
      PHD_OWN_RAS = 2'h1,
      PHD_OWN_HOST = 2'h2,
      PHD_OWN_SEG = 2'h3
   } phd_owner_t;

   // Where the current access goes.
   typedef enum logic [1:0] {
      PHD_TGT_LOCAL = 2'h0,
      PHD_TGT_ONCHIP = 2'h1,
      PHD_TGT_PERIPH = 2'h2,
      PHD_TGT_REGS = 2'h3
   } phd_target_t;

   // Internal word address: base scaled by 64 plus the word offset.
   function automatic logic [IADDR_W-1:0] phd_form_iaddr(input logic [BASE_W-1:0] base,
                                                        input logic [OFFS_W-1:0] offs);
      phd_form_iaddr = {base, 6'h00} + {14'h0000, offs};
   endfunction
endpackage
`default_nettype wire

/* src/phd_ram_if.sv */
// Port bundle between the access sequencer and the on-chip RAM.
`default_nettype none
interface phd_ram_if;
   import phd_pkg::*;
   logic [RAM_AW-1:0] addr; // Word index into the RAM.
   logic we; // Write strobe, one cycle per word.
   logic [DATA_W-1:0] wdata; // Word to store.
   logic [DATA_W-1:0] rdata; // Word read, one cycle after the address.
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire
